/* hdl/deflection_power_state_sequencer.sv */
// Power-state sequencer: POR, standby, soft-start, soft-down, protection, dips
// Behaviour
// - No acknowledge while power-on reset holds, supply below 8.3 V.
// - Leaving power-on reset enters standby with both control bits at start values.
// - Other control registers are undefined after power-on reset until written.
// - Sync-unlock flag high in standby, supply-on and soft-start.
// - Standby bit at 0 enables internal supply, output stages stay off.
// - Below 8.6 V writes cannot set the soft-start release bit.
// - Only complete three-byte write transfers change a register.
// - Soft-start ramps both duties up, enables ramps and both loops.
// - In full operation sync-unlock flag is low while first loop locked.
// - In full operation direct writes reach outputs at once.
// - Full operation is left by clearing soft-start, by a protection fault, or by power-down.
// - Soft-down lowers converter duty first, then line duty.
// - Protection floats drives, ramps, flag; blanks continuously; loops off.
// - Protection keeps all register contents.
// - Protection exits to standby, to soft-start, or on supply below 8.1 V.
// - Standby floats drivers and loses all registers except the two bits.
// - Dip below 8.6 V runs soft-down then internal soft-start.
// - Dip below 8.1 V disables drivers at once and enters standby.
// - Standby bit is bit 0 of subaddress 1A; 1 disables supply.
// - Soft-start release is bit 1 of subaddress 1A; 1 releases ramp pin.
// - Protection logic may clear both control bits by itself.
// - Subaddress MSB selects direct or buffered write mode.
`timescale 1ns/1ns
module deflection_power_state_sequencer
  import deflection_seq_pkg::*;
#(
  parameter int FILT_LEN  = FILTER_CYCLES,
  parameter int RAMP_STEP = RAMP_STEP_CYCLES
)
(
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  input  wire logic [LVL_COUNT-1:0] supply_above_async,
  input  wire logic                 protect_fault_async,
  input  wire logic                 first_frequency_loop_locked,
  input  wire logic                 frame_flyback,
  input  wire logic                 xfer_done,
  input  wire logic [3:0]           xfer_byte_count,
  input  wire logic [7:0]           xfer_subaddr,
  input  wire logic [7:0]           xfer_data,
  output logic                      ack_enable,
  output logic                      standby_request_bit,
  output logic                      soft_start_release_bit,
  output logic                      internal_supply_enable,
  output logic                      line_drive_output_oe,
  output logic                      converter_drive_output_oe,
  output logic [7:0]                line_duty,
  output logic [7:0]                converter_duty,
  output logic                      frame_ramp_output_a_oe,
  output logic                      frame_ramp_output_b_oe,
  output logic                      first_frequency_loop_enable,
  output logic                      second_phase_loop_enable,
  output logic                      sync_unlock_flag,
  output logic                      sync_unlock_flag_oe,
  output logic                      clamp_blank_output,
  output logic                      regs_retained,
  output logic                      reg_wr_strobe,
  output logic [6:0]                reg_wr_subaddr,
  output logic [7:0]                reg_wr_data,
  output logic [2:0]                seq_state
);

  localparam int RW = $clog2(RAMP_STEP + 1);

  logic                  rst_meta_r;
  logic                  rst_n;
  logic [CHAN_COUNT-1:0] chan_async;
  logic [CHAN_COUNT-1:0] chan_clean;
  logic                  ok_8v1;
  logic                  ok_8v3;
  logic                  ok_8v6;
  logic                  fault;
  seq_state_t            state_r;
  seq_state_t            state_nxt;
  logic [RW-1:0]         ramp_cnt_r;
  logic                  step_en;
  logic                  wr_ok;
  logic                  wr_direct;
  logic                  wr_buffered;
  logic                  pend_valid_r;
  logic [6:0]            pend_addr_r;
  logic [7:0]            pend_data_r;
  logic                  apply_en;
  logic [6:0]            apply_addr;
  logic [7:0]            apply_data;
  logic                  ctrl_wr;
  logic                  ctrl_wr_r;
  logic                  hw_clear;
  logic                  duties_max;
  logic                  duties_zero;
  logic                  drive_on_nxt;

  // Reset release through two flip-flops
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  assign chan_async = {protect_fault_async, supply_above_async};

  // Comparator and fault inputs, synchronised and filtered
  generate
    for (genvar i = 0; i < CHAN_COUNT; i++)
    begin : g_filt
      supply_level_filter #(
        .LEN       (FILT_LEN),
        .RESET_VAL (1'b0)
      ) u_filt (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .level_async (chan_async[i]),
        .level_clean (chan_clean[i])
      );
    end
  endgenerate

  assign ok_8v1 = chan_clean[LVL_8V1];
  assign ok_8v3 = chan_clean[LVL_8V3];
  assign ok_8v6 = chan_clean[LVL_8V6];
  assign fault  = chan_clean[CHAN_FAULT];

  // Ramp step divider
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ramp_cnt_r <= '0;
    else if (ramp_cnt_r == RW'(RAMP_STEP - 1))
      ramp_cnt_r <= '0;
    else
      ramp_cnt_r <= ramp_cnt_r + 1'b1;
  end

  assign step_en = (ramp_cnt_r == RW'(RAMP_STEP - 1));

  // Write decode, complete three-byte transfers only
  assign wr_ok       = xfer_done && (xfer_byte_count == XFER_WRITE_BYTES)
                       && (state_r != ST_POR);
  assign wr_direct   = wr_ok && !xfer_subaddr[SUBADDR_BUF_POS];
  assign wr_buffered = wr_ok && xfer_subaddr[SUBADDR_BUF_POS];

  // Direct writes apply at once, buffered ones at frame flyback
  always_comb
  begin
    apply_en   = 1'b0;
    apply_addr = xfer_subaddr[6:0];
    apply_data = xfer_data;
    if (wr_direct)
    begin
      apply_en = 1'b1;
    end
    else if (pend_valid_r && frame_flyback)
    begin
      apply_en   = 1'b1;
      apply_addr = pend_addr_r;
      apply_data = pend_data_r;
    end
  end

  assign ctrl_wr = apply_en && (apply_addr == CTRL_SUBADDR);

  // Pending buffered write; a new write wins over consumption
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_valid_r <= 1'b0;
      pend_addr_r  <= 7'h00;
      pend_data_r  <= 8'h00;
    end
    else if (state_nxt == ST_POR)
    begin
      pend_valid_r <= 1'b0;
    end
    else if (wr_buffered)
    begin
      pend_valid_r <= 1'b1;
      pend_addr_r  <= xfer_subaddr[6:0];
      pend_data_r  <= xfer_data;
    end
    else if (frame_flyback && !wr_direct)
    begin
      pend_valid_r <= 1'b0;
    end
  end

  // Strobe for the other control registers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_wr_strobe  <= 1'b0;
      reg_wr_subaddr <= 7'h00;
      reg_wr_data    <= 8'h00;
      ctrl_wr_r      <= 1'b0;
    end
    else
    begin
      reg_wr_strobe  <= apply_en && !ctrl_wr;
      reg_wr_subaddr <= apply_addr;
      reg_wr_data    <= apply_data;
      ctrl_wr_r      <= ctrl_wr && !hw_clear;
    end
  end

  // Hardware resets both control bits on POR or supply below 8.1 V
  assign hw_clear = (state_nxt == ST_POR) || ((state_r != ST_POR) && !ok_8v1);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      standby_request_bit    <= STANDBY_RESET;
      soft_start_release_bit <= SOFT_START_RESET;
    end
    else if (hw_clear)
    begin
      standby_request_bit    <= STANDBY_RESET;
      soft_start_release_bit <= SOFT_START_RESET;
    end
    else if (ctrl_wr)
    begin
      standby_request_bit <= apply_data[STANDBY_BIT_POS];
      if (ok_8v6 || !apply_data[SOFT_START_BIT_POS])
        soft_start_release_bit <= apply_data[SOFT_START_BIT_POS];
    end
  end

  assign duties_max  = (line_duty == DUTY_MAX) && (converter_duty == DUTY_MAX);
  assign duties_zero = (line_duty == DUTY_MIN) && (converter_duty == DUTY_MIN);

  // Next state
  always_comb
  begin
    state_nxt = state_r;
    if (state_r != ST_POR && !ok_8v1)
    begin
      state_nxt = ST_STANDBY;
    end
    else
    begin
      case (state_r)
        ST_POR:
          if (ok_8v3)
            state_nxt = ST_STANDBY;
        ST_STANDBY:
          if (!standby_request_bit)
            state_nxt = ST_SUPPLY_ON;
        ST_SUPPLY_ON:
          if (standby_request_bit)
            state_nxt = ST_STANDBY;
          else if (soft_start_release_bit)
            state_nxt = ST_SOFT_START;
        ST_SOFT_START, ST_FULL:
          if (fault)
            state_nxt = ST_PROTECT;
          else if (!ok_8v6)
            state_nxt = ST_DIP_DOWN;
          else if (!soft_start_release_bit)
            state_nxt = ST_SOFT_DOWN;
          else if (state_r == ST_SOFT_START && duties_max)
            state_nxt = ST_FULL;
        ST_SOFT_DOWN:
          if (duties_zero)
            state_nxt = standby_request_bit ? ST_STANDBY : ST_SUPPLY_ON;
        ST_DIP_DOWN:
          if (duties_zero && ok_8v6)
            state_nxt = soft_start_release_bit ? ST_SOFT_START : ST_SUPPLY_ON;
        ST_PROTECT:
          if (ctrl_wr_r && soft_start_release_bit)
            state_nxt = ST_SOFT_START;
          else if (ctrl_wr_r && standby_request_bit)
            state_nxt = ST_STANDBY;
        default:
          state_nxt = ST_POR;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= ST_POR;
    else
      state_r <= state_nxt;
  end

  // Duty ramps
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      line_duty      <= DUTY_MIN;
      converter_duty <= DUTY_MIN;
    end
    else if (state_nxt == ST_POR || state_nxt == ST_STANDBY || state_nxt == ST_SUPPLY_ON
             || state_nxt == ST_PROTECT)
    begin
      line_duty      <= DUTY_MIN;
      converter_duty <= DUTY_MIN;
    end
    else if (step_en && state_r == ST_SOFT_START)
    begin
      if (line_duty != DUTY_MAX)
        line_duty <= line_duty + 1'b1;
      if (converter_duty != DUTY_MAX)
        converter_duty <= converter_duty + 1'b1;
    end
    else if (step_en && (state_r == ST_SOFT_DOWN || state_r == ST_DIP_DOWN))
    begin
      if (converter_duty != DUTY_MIN)
        converter_duty <= converter_duty - 1'b1;
      else if (line_duty != DUTY_MIN)
        line_duty <= line_duty - 1'b1;
    end
  end

  assign drive_on_nxt = (state_nxt == ST_SOFT_START) || (state_nxt == ST_FULL)
                        || (state_nxt == ST_SOFT_DOWN) || (state_nxt == ST_DIP_DOWN);

  // Output stage enables, registered from the next state
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_enable                  <= 1'b0;
      internal_supply_enable      <= 1'b0;
      line_drive_output_oe        <= 1'b0;
      converter_drive_output_oe   <= 1'b0;
      frame_ramp_output_a_oe      <= 1'b0;
      frame_ramp_output_b_oe      <= 1'b0;
      first_frequency_loop_enable <= 1'b0;
      second_phase_loop_enable    <= 1'b0;
      clamp_blank_output          <= 1'b0;
      regs_retained               <= 1'b0;
      seq_state                   <= ST_POR;
    end
    else
    begin
      ack_enable                  <= (state_nxt != ST_POR);
      internal_supply_enable      <= (state_nxt != ST_POR) && (state_nxt != ST_STANDBY);
      line_drive_output_oe        <= drive_on_nxt;
      converter_drive_output_oe   <= drive_on_nxt;
      frame_ramp_output_a_oe      <= drive_on_nxt;
      frame_ramp_output_b_oe      <= drive_on_nxt;
      first_frequency_loop_enable <= drive_on_nxt;
      second_phase_loop_enable    <= drive_on_nxt;
      clamp_blank_output          <= (state_nxt == ST_PROTECT);
      regs_retained               <= (state_nxt != ST_POR)
                                     && (state_nxt != ST_STANDBY);
      seq_state                   <= state_nxt;
    end
  end

  // Sync-unlock flag
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_unlock_flag    <= 1'b1;
      sync_unlock_flag_oe <= 1'b1;
    end
    else
    begin
      sync_unlock_flag    <= (state_nxt == ST_FULL) ? !first_frequency_loop_locked
                                                    : 1'b1;
      sync_unlock_flag_oe <= (state_nxt != ST_PROTECT);
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  por_no_ack_a: assert property (ack_enable == (state_r != ST_POR))
    else $error("acknowledge enabled during power-on reset");
  por_exit_bits_a: assert property ((state_r == ST_POR && state_nxt == ST_STANDBY)
    |=> standby_request_bit && !soft_start_release_bit)
    else $error("control bits not at start values after power-on reset");
  unlock_high_a: assert property ((state_r inside {ST_STANDBY, ST_SUPPLY_ON, ST_SOFT_START})
    |-> sync_unlock_flag && sync_unlock_flag_oe)
    else $error("sync-unlock flag not high before full operation");
  supply_only_a: assert property ((state_r == ST_SUPPLY_ON) |-> internal_supply_enable
    && !line_drive_output_oe && !converter_drive_output_oe)
    else $error("output stage active with supply only");
  soft_blocked_a: assert property ((ctrl_wr && !hw_clear && apply_data[SOFT_START_BIT_POS]
    && !soft_start_release_bit && !ok_8v6) |=> !soft_start_release_bit)
    else $error("soft-start released below 8.6 V");
  short_xfer_a: assert property ((xfer_done && xfer_byte_count != XFER_WRITE_BYTES
    && !frame_flyback) |=> !reg_wr_strobe)
    else $error("incomplete transfer wrote a register");
  full_unlock_a: assert property ((state_r == ST_FULL)
    |-> sync_unlock_flag == !$past(first_frequency_loop_locked))
    else $error("sync-unlock flag does not follow loop lock");
  protect_float_a: assert property ((state_r == ST_PROTECT) |-> !line_drive_output_oe
    && !converter_drive_output_oe && !frame_ramp_output_a_oe && !sync_unlock_flag_oe
    && clamp_blank_output && !first_frequency_loop_enable && regs_retained)
    else $error("protection outputs wrong");
  down_order_a: assert property ((state_r == ST_SOFT_DOWN && state_nxt == ST_SOFT_DOWN
    && converter_duty != DUTY_MIN) |=> line_duty == $past(line_duty))
    else $error("line duty lowered before converter duty");
  dip_off_a: assert property ((state_r != ST_POR && !ok_8v1) |=> state_r == ST_STANDBY
    && !line_drive_output_oe && !converter_drive_output_oe)
    else $error("supply below 8.1 V did not force standby");
  protect_exit_a: assert property ((state_r == ST_PROTECT && ctrl_wr_r
    && soft_start_release_bit && ok_8v1) |=> state_r == ST_SOFT_START)
    else $error("protection not left on soft-start release");
  protect_hold_a: assert property ((state_r == ST_PROTECT && !ctrl_wr_r && ok_8v1)
    |=> state_r == ST_PROTECT)
    else $error("protection left without a control write");

  reach_full_c: cover property (state_r == ST_SOFT_START ##1 state_r == ST_FULL);
  reach_protect_c: cover property (state_r == ST_FULL ##1 state_r == ST_PROTECT);
  dip_restart_c: cover property (state_r == ST_DIP_DOWN ##1 state_r == ST_SOFT_START);
  down_standby_c: cover property (state_r == ST_SOFT_DOWN ##1 state_r == ST_STANDBY);

endmodule

/* hdl/supply_level_filter.sv */
// Two-stage synchroniser and persistence filter for one comparator input
`timescale 1ns/1ns
module supply_level_filter
  import deflection_seq_pkg::*;
#(
  parameter int   LEN       = FILTER_CYCLES,
  parameter logic RESET_VAL = 1'b0
)
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic level_async,
  output logic      level_clean
);

  localparam int CW = $clog2(LEN + 1);

  logic          meta_r;
  logic          sync_r;
  logic [CW-1:0] count_r;

  // Synchroniser
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= RESET_VAL;
      sync_r <= RESET_VAL;
    end
    else
    begin
      meta_r <= level_async;
      sync_r <= meta_r;
    end
  end

  // Output follows only a level that persists for LEN cycles
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_r     <= '0;
      level_clean <= RESET_VAL;
    end
    else if (sync_r == level_clean)
    begin
      count_r <= '0;
    end
    else if (count_r == CW'(LEN - 1))
    begin
      count_r     <= '0;
      level_clean <= sync_r;
    end
    else
    begin
      count_r <= count_r + 1'b1;
    end
  end

endmodule

/* shared/deflection_seq_pkg.sv */
// Constants and types for the deflection power-state sequencer
package deflection_seq_pkg;

  localparam int CLK_FREQ_MHZ = 125;

  // Supply comparator and fault filter
  localparam int FILTER_TIME_NS = 400;
  localparam int FILTER_CYCLES  = (FILTER_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;

  // Duty ramp step time during soft-start and soft-down
  localparam int RAMP_STEP_US     = 10;
  localparam int RAMP_STEP_CYCLES = RAMP_STEP_US * CLK_FREQ_MHZ;

  // Supply level channels
  localparam int LVL_COUNT = 3;
  localparam int LVL_8V1   = 0;
  localparam int LVL_8V3   = 1;
  localparam int LVL_8V6   = 2;
  localparam int CHAN_COUNT = 4;
  localparam int CHAN_FAULT = 3;

  // Control register
  localparam logic [6:0] CTRL_SUBADDR       = 7'h1A;
  localparam int         SUBADDR_BUF_POS    = 7;
  localparam int         STANDBY_BIT_POS    = 0;
  localparam int         SOFT_START_BIT_POS = 1;
  localparam logic       STANDBY_RESET      = 1'b1;
  localparam logic       SOFT_START_RESET   = 1'b0;

  // Write transfer length: address, subaddress, data
  localparam logic [3:0] XFER_WRITE_BYTES = 4'h3;

  // Drive duty limits
  localparam logic [7:0] DUTY_MIN = 8'h00;
  localparam logic [7:0] DUTY_MAX = 8'hFF;

  typedef enum logic [2:0] {
    ST_POR        = 3'b000,
    ST_STANDBY    = 3'b001,
    ST_SUPPLY_ON  = 3'b010,
    ST_SOFT_START = 3'b011,
    ST_FULL       = 3'b100,
    ST_SOFT_DOWN  = 3'b101,
    ST_DIP_DOWN   = 3'b110,
    ST_PROTECT    = 3'b111
  } seq_state_t;

endpackage

/* tb/deflection_power_state_sequencer_test.sv */
// Self-checking bench for the power-state sequencer
`timescale 1ns/1ns
module deflection_power_state_sequencer_test;
  import deflection_seq_pkg::*;
  localparam int FL = 3;
  localparam int RS = 2;
  logic        sys_clk, nrst, protect_fault_async, frame_flyback;
  logic        first_frequency_loop_locked, xfer_done;
  logic [2:0]  supply_above_async, seq_state;
  logic [3:0]  xfer_byte_count;
  logic [7:0]  xfer_subaddr, xfer_data, line_duty, converter_duty, reg_wr_data;
  logic [6:0]  reg_wr_subaddr;
  logic        ack_enable, standby_request_bit, soft_start_release_bit;
  logic        internal_supply_enable, line_drive_output_oe, converter_drive_output_oe;
  logic        frame_ramp_output_a_oe, frame_ramp_output_b_oe, regs_retained;
  logic        first_frequency_loop_enable, second_phase_loop_enable, reg_wr_strobe;
  logic        sync_unlock_flag, sync_unlock_flag_oe, clamp_blank_output, exp_sb, exp_ss;
  logic [14:0] wq[$];
  logic [14:0] w;
  logic [7:0]  d;
  int          err_count, n_checks, cyc, seed, i;

  deflection_power_state_sequencer #(.FILT_LEN(FL), .RAMP_STEP(RS))
    deflection_power_state_sequencer_i
  (
    .sys_clk, .nrst, .supply_above_async, .protect_fault_async,
    .first_frequency_loop_locked, .frame_flyback, .xfer_done, .xfer_byte_count,
    .xfer_subaddr, .xfer_data, .ack_enable, .standby_request_bit,
    .soft_start_release_bit, .internal_supply_enable, .line_drive_output_oe,
    .converter_drive_output_oe, .line_duty, .converter_duty, .frame_ramp_output_a_oe,
    .frame_ramp_output_b_oe, .first_frequency_loop_enable, .second_phase_loop_enable,
    .sync_unlock_flag, .sync_unlock_flag_oe, .clamp_blank_output, .regs_retained,
    .reg_wr_strobe, .reg_wr_subaddr, .reg_wr_data, .seq_state
  );

  host_ctrl_model host_ctrl_model_i
  (
    .sys_clk, .xfer_done, .xfer_byte_count, .xfer_subaddr, .xfer_data
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic close_out;
    $display("Checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Outputs expected in state s
  task automatic ck_out(input int s);
    logic dr;
    dr = (s >= 3 && s <= 6);
    chk(seq_state, s[2:0]);
    chk({line_drive_output_oe, converter_drive_output_oe, frame_ramp_output_a_oe,
         frame_ramp_output_b_oe, first_frequency_loop_enable,
         second_phase_loop_enable}, {6{dr}});
    chk({sync_unlock_flag_oe, clamp_blank_output}, {s != 7, s == 7});
    chk({ack_enable, regs_retained, internal_supply_enable}, {s != 0, s > 1, s > 1});
    chk({standby_request_bit, soft_start_release_bit}, {exp_sb, exp_ss});
    if (s != 4 && s != 7)
      chk(sync_unlock_flag, 1'b1);
  endtask

  task automatic wait_st(input int s, input int lim);
    int n;
    n = 0;
    while (seq_state !== s[2:0] && n < lim)
    begin
      tick(1);
      n++;
    end
    ck_out(s);
  endtask

  // Write through the host and update the reference bits
  task automatic wr(input logic [7:0] sub, input logic [7:0] dat, input logic [3:0] cnt);
    logic live;
    live = (seq_state !== 3'd0) && (cnt == 4'h3);
    host_ctrl_model_i.send(sub, dat, cnt, (sub == {1'b0, CTRL_SUBADDR}) ? 2 : 1);
    if (live && sub == {1'b0, CTRL_SUBADDR})
    begin
      exp_sb = dat[0];
      if (!dat[1] || supply_above_async[2])
        exp_ss = dat[1];
    end
    else if (live && !sub[7])
      wq.push_back({sub[6:0], dat});
  endtask

  always @(negedge sys_clk)
    if (reg_wr_strobe === 1'b1)
    begin
      w = (wq.size() > 0) ? wq.pop_front() : 15'h7FFF;
      chk({reg_wr_subaddr, reg_wr_data}, {w[14:8], w[7:0]});
    end

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      close_out;
    end
  end

  initial
  begin
    err_count = 0;
    n_checks = 0;
    cyc = 0;
    exp_sb = 1'b1;
    exp_ss = 1'b0;
    nrst = 1'b0;
    supply_above_async = 3'b000;
    protect_fault_async = 1'b0;
    first_frequency_loop_locked = 1'b0;
    frame_flyback = 1'b0;
    seed = $urandom(55169);
    tick(16);
    nrst = 1'b1;
    wr(8'h1A, 8'h00, 4'h3);
    tick(4);
    ck_out(0);
    supply_above_async = 3'b111;
    wait_st(1, 40);
    wr(8'h1A, 8'h00, 4'h2);
    tick(4);
    ck_out(1);
    wr(8'h1A, 8'h00, 4'h3);
    wait_st(2, 8);
    supply_above_async = 3'b011;
    tick(12);
    wr(8'h1A, 8'h02, 4'h3);
    tick(4);
    ck_out(2);
    supply_above_async = 3'b111;
    tick(30);
    wr(8'h1A, 8'h02, 4'h3);
    wait_st(3, 8);
    wait_st(4, 1500);
    chk({line_duty, converter_duty}, 16'hFFFF);
    for (i = 0; i < 8; i++)
    begin
      first_frequency_loop_locked = $urandom_range(1);
      tick(3);
      chk(sync_unlock_flag, !first_frequency_loop_locked);
    end
    wr(8'h1A, 8'h03, 4'h3);
    tick(6);
    ck_out(4);
    for (i = 3; i < 7; i++)
    begin
      d = $urandom;
      wr(i[7:0], d, 4'h3);
    end
    tick(2);
    chk(wq.size(), 0);
    wr(8'h88, d, 4'h3);
    tick(4);
    wq.push_back({7'h08, d});
    frame_flyback = 1'b1;
    tick(1);
    frame_flyback = 1'b0;
    tick(2);
    chk(wq.size(), 0);
    wr(8'h1A, 8'h01, 4'h3);
    wait_st(5, 8);
    for (i = 0; i < 1500 && converter_duty !== 8'h00; i++)
      tick(1);
    chk(line_duty, 8'hFF);
    wait_st(1, 1500);
    wr(8'h1A, 8'h00, 4'h3);
    wait_st(2, 8);
    wr(8'h1A, 8'h02, 4'h3);
    wait_st(3, 8);
    protect_fault_async = 1'b1;
    wait_st(7, 12);
    chk({line_duty, converter_duty}, 16'h0000);
    protect_fault_async = 1'b0;
    tick(8);
    wr(8'h1A, 8'h02, 4'h3);
    wait_st(3, 8);
    protect_fault_async = 1'b1;
    wait_st(7, 12);
    wr(8'h1A, 8'h01, 4'h3);
    wait_st(1, 12);
    protect_fault_async = 1'b0;
    wr(8'h1A, 8'h00, 4'h3);
    wait_st(2, 8);
    tick(30);
    wr(8'h1A, 8'h02, 4'h3);
    wait_st(4, 1500);
    supply_above_async = 3'b011;
    wait_st(6, 12);
    supply_above_async = 3'b111;
    wait_st(3, 1500);
    wait_st(4, 1500);
    supply_above_async = 3'b000;
    exp_sb = 1'b1;
    exp_ss = 1'b0;
    wait_st(1, 10);
    close_out;
  end
endmodule

/* tb/host_ctrl_model.sv */
// Host model driving register write transfers of a given byte count
`timescale 1ns/1ns
module host_ctrl_model
(
  input  wire logic  sys_clk,
  output logic       xfer_done,
  output logic [3:0] xfer_byte_count,
  output logic [7:0] xfer_subaddr,
  output logic [7:0] xfer_data
);
  initial
  begin
    xfer_done = 1'b0;
    xfer_byte_count = 4'h0;
    xfer_subaddr = 8'h00;
    xfer_data = 8'h00;
  end

  // One transfer, held for rep cycles when repeated
  task automatic send(input logic [7:0] sub, input logic [7:0] dat,
                      input logic [3:0] cnt, input int rep);
    @(posedge sys_clk);
    #1;
    xfer_done = 1'b1;
    xfer_byte_count = cnt;
    xfer_subaddr = sub;
    xfer_data = dat;
    repeat (rep) @(posedge sys_clk);
    #1;
    xfer_done = 1'b0;
    xfer_byte_count = ~cnt;
    xfer_subaddr = ~sub;
    xfer_data = ~dat;
  endtask
endmodule
